// ===== rtl/ssm_pkg.sv
// package for the safety stop monitor: constants, codes and carrier types
package ssm_pkg;

   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned HOLD_US = 2000;
   localparam int unsigned HOLD_CYC = (HOLD_US * (CLK_HZ / 1_000_000));
   localparam int unsigned CNT_W = 17;
   localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);

   // output assignment codes
   localparam logic [7:0] FC_WIDTH_PAD = 8'h00;
   localparam logic [7:0] FC_STOP_POS = 8'd80;
   localparam logic [7:0] FC_HEALTH_POS = 8'd81;
   localparam logic [7:0] FC_STOP_NEG = 8'd180;
   localparam logic [7:0] FC_HEALTH_NEG = 8'd181;
   localparam logic [7:0] FC_RUNNING = 8'd0;
   localparam logic [7:0] FC_FREQ_DET = 8'd4;
   localparam logic [7:0] FC_ALARM = 8'd99;

   // register map, word addresses
   localparam logic [3:0] REG_ASSIGN_A = 4'h0;
   localparam logic [3:0] REG_ASSIGN_B = 4'h1;
   localparam logic [3:0] REG_ASSIGN_C = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_IRQ_STAT = 4'h4;
   localparam logic [3:0] REG_IRQ_MASK = 4'h5;
   localparam logic [3:0] REG_FAULT = 4'h6;

   localparam logic [7:0] ASSIGN_A_RST = FC_RUNNING;
   localparam logic [7:0] ASSIGN_B_RST = FC_FREQ_DET;
   localparam logic [7:0] ASSIGN_C_RST = FC_ALARM;

   // interrupt bit positions
   localparam int unsigned IRQ_STOP = 0;
   localparam int unsigned IRQ_FAIL = 1;
   localparam int unsigned IRQ_DRIVE = 2;
   localparam int unsigned IRQ_W = 3;

   typedef enum logic [2:0] {
      DISP_NONE,
      DISP_STOP_ACTIVE,
      DISP_PROTECTION_FAULT,
      DISP_FAULT_SIX,
      DISP_FAULT_SEVEN,
      DISP_PROCESSOR_FAULT
   } ssm_disp_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ssm_bus_req_type;

   typedef struct packed {
      logic stop_ind;
      logic health_ind;
      logic drive_en;
      logic fail;
   } ssm_state_type;

endpackage : ssm_pkg

// ===== rtl/ssm_top.sv
// safety stop monitor: channel qualification, drive enable, indicators
//
// Behaviour
// - open channel requests stop, shorted does not
// - channel change accepted after stable 2 ms
// - drive only with power, both shorted, no failure
// - discordant channels count as circuit failure
// - stop indicator only when stopped without failure
// - health indicator on when no failure, power
// - active output means transistor conducts
// - stop display when both open, no failure; code also requires power on
// - failure shows one of four fault codes
// - reset assigns running and frequency functions
// - running terminal off on fault if health-assigned
// - channels referenced to input common always
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module ssm_top
   import ssm_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // stop channels: high = shorted to input common terminal
   input wire logic stop_channel_one_i,
   input wire logic stop_channel_two_i,
   // system status
   input wire logic power_on_i,
   input wire logic int_fail_i,
   input wire logic [1:0] int_fail_kind_i,
   // ordinary functions for terminals
   input wire logic running_i,
   input wire logic freq_det_i,
   input wire logic alarm_i,
   // register port
   input wire ssm_bus_req_type bus_i,
   output logic [7:0] rdata_o,
   // results
   output logic drive_en_o,
   output logic [2:0] term_on_o,
   output ssm_disp_type disp_o,
   output logic irq_o
);

   logic [1:0] raw_w;
   logic [1:0] s1_q, s2_q, s3_q;
   logic [1:0] filt_q;
   logic [CNT_W-1:0] cnt_q [2];
   logic [7:0] asg_q [3];
   logic [IRQ_W-1:0] ist_q, imsk_q, ev_w;
   ssm_state_type st_w, st_q;
   logic disc_w, fail_w;
   logic [2:0] term_d;

   // shorted to common reads high regardless of input logic selection
   assign raw_w = {stop_channel_two_i, stop_channel_one_i};

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q <= 2'b00;
         s2_q <= 2'b00;
         s3_q <= 2'b00;
      end else begin
         s1_q <= raw_w;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_chan
      // restart whenever the synchronised level equals the filtered level or moves
      always_ff @(posedge mclk_i or posedge rst_i) begin
         if (rst_i) begin
            cnt_q[g] <= '0;
            filt_q[g] <= 1'b0;
         end else if (s2_q[g] != s3_q[g] || s3_q[g] == filt_q[g]) begin
            cnt_q[g] <= '0;
         end else if (cnt_q[g] == HOLD_LAST) begin
            cnt_q[g] <= '0;
            filt_q[g] <= s3_q[g];
         end else begin
            cnt_q[g] <= cnt_q[g] + 1'b1;
         end
      end
   end

   // decision: filt low = open = stop requested
   always_comb begin
      disc_w = filt_q[0] ^ filt_q[1];
      fail_w = int_fail_i | disc_w;
      st_w.fail = fail_w;
      st_w.drive_en = power_on_i & (&filt_q) & ~fail_w;
      st_w.stop_ind = power_on_i & ~(&filt_q) & ~fail_w;
      st_w.health_ind = power_on_i & ~fail_w;
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_w;
      end
   end

   assign drive_en_o = st_q.drive_en;

   // terminal routing; a high term bit means the transistor conducts
   for (genvar t = 0; t < 3; t++) begin : g_term
      always_comb begin
         unique case (asg_q[t])
            FC_STOP_POS: term_d[t] = st_q.stop_ind;
            FC_STOP_NEG: term_d[t] = ~st_q.stop_ind;
            FC_HEALTH_POS: term_d[t] = st_q.health_ind;
            FC_HEALTH_NEG: term_d[t] = ~st_q.health_ind;
            FC_RUNNING: term_d[t] = running_i;
            FC_FREQ_DET: term_d[t] = freq_det_i;
            FC_ALARM: term_d[t] = alarm_i;
            default: term_d[t] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         term_on_o <= 3'b000;
      end else begin
         term_on_o <= term_d;
      end
   end

   // operator display
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         disp_o <= DISP_NONE;
      end else if (!st_w.fail) begin
         disp_o <= (power_on_i && filt_q == 2'b00) ? DISP_STOP_ACTIVE : DISP_NONE;
      end else if (disc_w) begin
         disp_o <= DISP_PROTECTION_FAULT;
      end else begin
         unique case (int_fail_kind_i)
            2'd0: disp_o <= DISP_PROTECTION_FAULT;
            2'd1: disp_o <= DISP_FAULT_SIX;
            2'd2: disp_o <= DISP_FAULT_SEVEN;
            2'd3: disp_o <= DISP_PROCESSOR_FAULT;
         endcase
      end
   end

   // output assignment registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         asg_q[0] <= ASSIGN_A_RST;
         asg_q[1] <= ASSIGN_B_RST;
         asg_q[2] <= ASSIGN_C_RST;
      end else if (bus_i.wr) begin
         if (bus_i.addr == REG_ASSIGN_A) asg_q[0] <= bus_i.wdata;
         if (bus_i.addr == REG_ASSIGN_B) asg_q[1] <= bus_i.wdata;
         if (bus_i.addr == REG_ASSIGN_C) asg_q[2] <= bus_i.wdata;
      end
   end

   // interrupts: rising edges of stop, failure, drive enable
   assign ev_w = {st_w.drive_en & ~st_q.drive_en, st_w.fail & ~st_q.fail,
                  st_w.stop_ind & ~st_q.stop_ind};

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ist_q <= '0;
         imsk_q <= '0;
      end else begin
         // a new event wins over a simultaneous clear
         if (bus_i.wr && bus_i.addr == REG_IRQ_STAT) begin
            ist_q <= (ist_q & ~bus_i.wdata[IRQ_W-1:0]) | ev_w;
         end else begin
            ist_q <= ist_q | ev_w;
         end
         if (bus_i.wr && bus_i.addr == REG_IRQ_MASK) imsk_q <= bus_i.wdata[IRQ_W-1:0];
      end
   end

   assign irq_o = |(ist_q & imsk_q);

   // read data, one cycle after the strobe
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (bus_i.rd) begin
         unique case (bus_i.addr)
            REG_ASSIGN_A: rdata_o <= asg_q[0];
            REG_ASSIGN_B: rdata_o <= asg_q[1];
            REG_ASSIGN_C: rdata_o <= asg_q[2];
            REG_STATUS: rdata_o <= {2'b00, filt_q, st_q};
            REG_IRQ_STAT: rdata_o <= {5'b0_0000, ist_q};
            REG_IRQ_MASK: rdata_o <= {5'b0_0000, imsk_q};
            REG_FAULT: rdata_o <= {5'b0_0000, disp_o};
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // checks: length of the current synchronised run per channel, held at the hold limit
   // so that a filter update can be traced back to a full quiet period
   logic [CNT_W-1:0] run_q [2];

   for (genvar g = 0; g < 2; g++) begin : g_chk
      always_ff @(posedge mclk_i or posedge rst_i) begin
         if (rst_i) begin
            run_q[g] <= '0;
         end else if (s2_q[g] != s3_q[g]) begin
            run_q[g] <= '0;
         end else if (run_q[g] != HOLD_LAST) begin
            run_q[g] <= run_q[g] + 1'b1;
         end
      end

      a_hold_time: assert property (@(posedge mclk_i) disable iff (rst_i)
         $changed(filt_q[g]) |-> $past(run_q[g]) == HOLD_LAST)
         else $error("channel level taken before the hold time");
      a_filter_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
         $changed(filt_q[g]) |-> $past(s3_q[g]) == filt_q[g])
         else $error("filter changed to an unseen level");
   end

   // drive and indicators
   a_drive_needs_both: assert property (@(posedge mclk_i) disable iff (rst_i)
      drive_en_o |-> $past(power_on_i) && $past(filt_q) == 2'b11 && !$past(int_fail_i))
      else $error("drive enabled without both channels shorted");
   a_drive_on: assert property (@(posedge mclk_i) disable iff (rst_i)
      power_on_i && filt_q == 2'b11 && !int_fail_i |=> drive_en_o)
      else $error("drive not enabled with both channels shorted");
   a_power_off: assert property (@(posedge mclk_i) disable iff (rst_i)
      !power_on_i |=> !drive_en_o && !st_q.stop_ind && !st_q.health_ind)
      else $error("drive or indicator active with power off");
   a_disc_fail: assert property (@(posedge mclk_i) disable iff (rst_i)
      (filt_q[0] != filt_q[1]) |=> !st_q.stop_ind && !st_q.health_ind && !drive_en_o)
      else $error("discordant channels did not force failure");
   a_stop_ind_rule: assert property (@(posedge mclk_i) disable iff (rst_i)
      st_q.stop_ind |-> !drive_en_o && !st_q.fail)
      else $error("stop indicator with drive or failure");
   a_stop_ind_on: assert property (@(posedge mclk_i) disable iff (rst_i)
      power_on_i && filt_q == 2'b00 && !int_fail_i |=> st_q.stop_ind)
      else $error("stop indicator missing while stopped");
   a_health_rule: assert property (@(posedge mclk_i) disable iff (rst_i)
      power_on_i && !int_fail_i && filt_q[0] == filt_q[1] |=> st_q.health_ind)
      else $error("health indicator missing");
   a_health_fail: assert property (@(posedge mclk_i) disable iff (rst_i)
      int_fail_i |=> !st_q.health_ind && st_q.fail)
      else $error("health indicator on during failure");

   // operator display
   a_disp_stop: assert property (@(posedge mclk_i) disable iff (rst_i)
      power_on_i && filt_q == 2'b00 && !int_fail_i |=> disp_o == DISP_STOP_ACTIVE)
      else $error("stop display missing");
   a_disp_none: assert property (@(posedge mclk_i) disable iff (rst_i)
      power_on_i && filt_q == 2'b11 && !int_fail_i |=> disp_o == DISP_NONE)
      else $error("stop display while drive allowed");
   a_disp_fault: assert property (@(posedge mclk_i) disable iff (rst_i)
      int_fail_i |=> disp_o inside {DISP_PROTECTION_FAULT, DISP_FAULT_SIX,
                                    DISP_FAULT_SEVEN, DISP_PROCESSOR_FAULT})
      else $error("fault code missing");
   a_disp_disc: assert property (@(posedge mclk_i) disable iff (rst_i)
      filt_q[0] != filt_q[1] |=> disp_o == DISP_PROTECTION_FAULT)
      else $error("discordance without protection fault code");

   // terminal routing; a negative code shows the inverse of its indicator
   for (genvar t = 0; t < 3; t++) begin : g_route_chk
      a_route_stop: assert property (@(posedge mclk_i) disable iff (rst_i)
         asg_q[t] == FC_STOP_POS |=> term_on_o[t] == $past(st_q.stop_ind))
         else $error("stop indicator not routed");
      a_route_stop_neg: assert property (@(posedge mclk_i) disable iff (rst_i)
         asg_q[t] == FC_STOP_NEG |=> term_on_o[t] != $past(st_q.stop_ind))
         else $error("inverted stop indicator not routed");
      a_route_health: assert property (@(posedge mclk_i) disable iff (rst_i)
         asg_q[t] == FC_HEALTH_POS |=> term_on_o[t] == $past(st_q.health_ind))
         else $error("health indicator not routed");
      a_route_health_neg: assert property (@(posedge mclk_i) disable iff (rst_i)
         asg_q[t] == FC_HEALTH_NEG |=> term_on_o[t] != $past(st_q.health_ind))
         else $error("inverted health indicator not routed");
   end

   a_run_term_fault: assert property (@(posedge mclk_i) disable iff (rst_i)
      asg_q[0] == FC_HEALTH_POS && int_fail_i ##1 asg_q[0] == FC_HEALTH_POS
         |=> !term_on_o[0])
      else $error("running terminal still on after a fault");

   // interrupts and register port
   a_irq_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
      ev_w != '0 |=> (ist_q & $past(ev_w)) == $past(ev_w))
      else $error("interrupt event lost");
   a_irq_level: assert property (@(posedge mclk_i) disable iff (rst_i)
      irq_o == ((ist_q & imsk_q) != '0))
      else $error("interrupt level wrong");
   a_read_gap: assert property (@(posedge mclk_i) disable iff (rst_i)
      !bus_i.rd |=> rdata_o == 8'h00)
      else $error("read data outside the read cycle");

   c_drive: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(drive_en_o));
   c_stop: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(st_q.stop_ind));
   c_disc: cover property (@(posedge mclk_i) disable iff (rst_i) filt_q == 2'b01);
   c_irq: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(irq_o));
   c_fault: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(st_q.fail));

endmodule : ssm_top

// ===== sim/ssm_relay_model.sv
// behavioural safety relay module driving the two stop channels
`timescale 1ns/1ps
module ssm_relay_model (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // contact commands, high = close contact
   input wire logic close_one_i,
   input wire logic close_two_i,
   // stop channels, high = shorted to input common terminal
   output logic stop_channel_one_o,
   output logic stop_channel_two_o
);
   // contacts open (stop requested) until commanded; the bench owns hold times
   // health and stop indicators are only ever monitored, never fed onward
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         stop_channel_one_o <= 1'b0;
         stop_channel_two_o <= 1'b0;
      end else begin
         stop_channel_one_o <= close_one_i;
         stop_channel_two_o <= close_two_i;
      end
   end
endmodule : ssm_relay_model

// ===== sim/tb_top.sv
// self-checking testbench for the safety stop monitor
`timescale 1ns/1ps
module tb_top;
   import ssm_pkg::*;
   logic mclk_i = 0, rst_i = 1, c1 = 0, c2 = 0, s1, s2, pwr = 1, fl = 0;
   logic [1:0] fk = 0;
   logic run = 1, fdet = 0, alm = 1, drv, irq;
   ssm_bus_req_type bus = '0;
   logic [7:0] rd;
   logic [2:0] term;
   ssm_disp_type disp;
   int fail_count = 0, n_checks = 0, n;
   initial forever #12.5 mclk_i = ~mclk_i;
   ssm_relay_model rly_u (.mclk_i(mclk_i), .rst_i(rst_i), .close_one_i(c1), .close_two_i(c2),
      .stop_channel_one_o(s1), .stop_channel_two_o(s2));
   ssm_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .stop_channel_one_i(s1),
      .stop_channel_two_i(s2), .power_on_i(pwr), .int_fail_i(fl), .int_fail_kind_i(fk),
      .running_i(run), .freq_det_i(fdet), .alarm_i(alm), .bus_i(bus), .rdata_o(rd),
      .drive_en_o(drv), .term_on_o(term), .disp_o(disp), .irq_o(irq));
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk_byte
   task automatic chk_disp(input ssm_disp_type exp);
      chk_byte({5'h0, disp}, {5'h0, exp}, "display");
   endtask : chk_disp
   task automatic tick(input int k);
      repeat (k) @(posedge mclk_i);
      #1;
   endtask : tick
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i);
      bus <= '0;
   endtask : bus_wr
   task automatic bus_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_i);
      bus <= '0;
      #1;
      chk_byte(rd, exp, "read");
   endtask : bus_rd
   task automatic set_fail(input logic v);
      @(posedge mclk_i);
      fl <= v;
      tick(5);
   endtask : set_fail
   task automatic t_reset_vals;
      bus_rd(REG_ASSIGN_A, 8'h00);
      bus_rd(REG_ASSIGN_B, 8'h04);
      bus_rd(REG_ASSIGN_C, 8'h63);
      bus_rd(4'hF, 8'h00);
      bus_rd(REG_STATUS, 8'h0C);
      chk_byte({5'h0, term}, 8'h05, "terms");
      chk_disp(DISP_STOP_ACTIVE);
   endtask : t_reset_vals
   task automatic t_route;
      bus_wr(REG_ASSIGN_A, 8'd81);
      bus_wr(REG_ASSIGN_B, 8'd80);
      bus_wr(REG_ASSIGN_C, 8'd181);
      tick(4);
      chk_byte({5'h0, term}, 8'h03, "route");
      for (int k = 0; k < 4; k++) begin
         @(posedge mclk_i);
         fk <= 2'(k);
         set_fail(1'b1);
         chk_disp(ssm_disp_type'(3'(k + 2)));
         chk_byte({5'h0, term}, 8'h04, "fail terms");
         set_fail(1'b0);
      end
      bus_wr(REG_ASSIGN_C, 8'd180);
      tick(4);
      chk_byte({5'h0, term}, 8'h03, "negative stop");
      bus_rd(REG_ASSIGN_C, 8'hB4);
      bus_wr(REG_ASSIGN_C, 8'd181);
   endtask : t_route
   task automatic t_irq;
      bus_wr(REG_IRQ_MASK, 8'h00);
      bus_wr(REG_IRQ_STAT, 8'h07);
      tick(2);
      chk_byte({7'h0, irq}, 8'h00, "irq clear");
      set_fail(1'b1);
      bus_rd(REG_IRQ_STAT, 8'h02);
      chk_byte({7'h0, irq}, 8'h00, "irq masked");
      bus_wr(REG_IRQ_MASK, 8'h02);
      tick(2);
      chk_byte({7'h0, irq}, 8'h01, "irq raised");
      bus_wr(REG_IRQ_STAT, 8'h02);
      tick(2);
      chk_byte({7'h0, irq}, 8'h00, "irq w1c");
      set_fail(1'b0);
   endtask : t_irq
   task automatic t_power;
      @(posedge mclk_i);
      pwr <= 1'b0;
      tick(5);
      chk_byte({7'h0, drv}, 8'h00, "drive off");
      chk_byte({5'h0, term}, 8'h04, "power terms");
      @(posedge mclk_i);
      pwr <= 1'b1;
      tick(5);
   endtask : t_power
   task automatic t_filter;
      time t0;
      bus_wr(REG_IRQ_STAT, 8'h07);
      @(posedge mclk_i);
      c1 <= 1'b1;
      c2 <= 1'b1;
      tick(2000);
      @(posedge mclk_i);
      c1 <= 1'b0;
      c2 <= 1'b0;
      tick(100);
      bus_rd(REG_STATUS, 8'h0C);
      @(posedge mclk_i);
      c1 <= 1'b1;
      t0 = $time;
      repeat (200) @(posedge mclk_i);
      c2 <= 1'b1;
      #1;
      for (n = 0; n < 80300 && disp !== DISP_PROTECTION_FAULT; n++) tick(1);
      if (disp !== DISP_PROTECTION_FAULT) begin
         fail_count++;
         $display("BAD %0t discordance never seen", $time);
         return;
      end
      n = int'(($time - t0) / 25);
      chk_byte(8'((n >= 80000) && (n <= 80100)), 8'h01, "hold one");
      tick(2);
      chk_byte({4'h0, drv, term}, 8'h04, "discordant");
      chk_disp(DISP_PROTECTION_FAULT);
      bus_rd(REG_STATUS, 8'h11);
      for (n = 0; n < 80300 && drv !== 1'b1; n++) tick(1);
      if (drv !== 1'b1) begin
         fail_count++;
         $display("BAD %0t drive never enabled", $time);
         return;
      end
      n = int'(($time - t0) / 25) - 200;
      chk_byte(8'((n >= 80000) && (n <= 80100)), 8'h01, "hold time");
      tick(3);
      chk_byte({5'h0, term}, 8'h01, "run terms");
      bus_rd(REG_STATUS, 8'h36);
      chk_disp(DISP_NONE);
      bus_rd(REG_IRQ_STAT, 8'h06);
      set_fail(1'b1);
      chk_byte({6'h0, drv, term[0]}, 8'h00, "fault stop");
      set_fail(1'b0);
   endtask : t_filter
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      tick(8);
      t_reset_vals();
      t_route();
      t_irq();
      t_filter();
      t_power();
      print_verdict();
   end
endmodule : tb_top
